/* File: rtl/gfr_router.v */
// Function
// - Function code 0000 drives the pin constantly low.
// - Code 0001 outputs two-level supply waveform; code 1001 the multi-level one.
// - Code 0010 drives the pin from its own output level bit, bits 2-0.
// - Code 0011 both-channels automute; 0100 left automute; 0101 right automute.
// - Code 0110 outputs clock-invalid: clock error or missing clock.
// - Code 1000 routes active-low warning; code 1011 routes active-low fault.
// - Code 1100 outputs serial clock; code 1101 outputs serial PICO data.
// - Two-bit input fields: 00 none, 01/10/11 take pin zero/one/two.
// - Pin routed as reset input survives the reset it raises.
// - Asserted active-low mute input on routed pin requests high-impedance state.
// - Invert bits 2-0 flip each pin's final output level; reset none.
// - State report: 00 deep sleep, 01 sleep, 10 high impedance, 11 play.
// - Per-pin enable bit: cleared is input, set drives the selected function.
`timescale 1ns/1ps
`include "gfr_defines.vh"

module gfr_router #(
    parameter [7:0] SILICON_ID = 8'h5A  // Arbitrary value, not tied to any part
) (
    // Clock and reset
    input  wire        i_clock,
    input  wire        i_rst,
    // AXI4-Lite write address and data
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    output wire [1:0]  s_axi_bresp,
    // AXI4-Lite read
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    input  wire [31:0] s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    // Internal status and waveforms
    input  wire        i_two_level_wave,
    input  wire        i_multi_level_wave,
    input  wire        i_automute_left,
    input  wire        i_automute_right,
    input  wire        i_clock_error,
    input  wire        i_clock_missing,
    input  wire        i_warning_out_n,
    input  wire        i_fault_out_n,
    input  wire        i_spi_clock,
    input  wire        i_spi_pico,
    input  wire [1:0]  i_state_code,
    // General pins
    input  wire [2:0]  i_general_pin,
    output wire [2:0]  o_general_pin,
    output wire [2:0]  o_general_pin_oe,
    // Inputs taken from pins
    output wire        o_mute_n,
    output wire        o_hiz_request,
    output wire        o_reset_n,
    output wire        o_phase_sync,
    output wire        o_serial_data_in,
    // Interrupt
    output wire        o_irq
);

    reg         awready_q;
    reg         wready_q;
    reg         bvalid_q;
    reg  [1:0]  bresp_q;
    reg         arready_q;
    reg         rvalid_q;
    reg  [31:0] rdata_q;
    reg  [1:0]  rresp_q;
    reg         aw_full_q;
    reg         w_full_q;
    reg  [7:0]  waddr_q;
    reg  [7:0]  wdata_q;
    reg         wlane_q;

    reg  [2:0]  dir_q;
    reg  [11:0] func_q;
    reg  [7:0]  route_q;
    reg  [2:0]  level_q;
    reg  [2:0]  invert_q;
    reg  [3:0]  irq_status_q;
    reg  [3:0]  irq_enable_q;
    reg         irq_q;

    reg  [2:0]  pin_q;
    reg  [2:0]  pin_oe_q;
    reg         mute_n_q;
    reg         hiz_q;
    reg         reset_n_q;
    reg         sync_q;
    reg         data_in_q;
    reg         fault_prev_q;
    reg         warn_prev_q;
    reg         clk_bad_prev_q;
    reg         mute_prev_q;

    wire        clock_bad = i_clock_error | i_clock_missing;
    wire        do_write  = aw_full_q & w_full_q & ~bvalid_q;
    wire        wr_hit    = do_write & wlane_q;
    wire        soft_rst  = ~reset_n_q;
    wire [3:0]  events;
    wire [2:0]  pin_level;
    wire [1:0]  rst_pick  = route_q[`GFR_RT_RESET_LSB +: 2];
    reg         rd_ok;
    reg  [7:0]  rd_byte;
    reg         wr_ok;

    // Pick the level of the pin a routing field names; none reads as idle
    function pick_pin;
        input [1:0] code;
        input [2:0] pins;
        input       idle;
        begin
            case (code)
                2'h1:    pick_pin = pins[0];
                2'h2:    pick_pin = pins[1];
                2'h3:    pick_pin = pins[2];
                default: pick_pin = idle;
            endcase
        end
    endfunction

    // Pins 0..2 map to reset routing codes 1..3
    function [2:0] reset_keep;
        input [1:0] code;
        begin
            case (code)
                2'h1:    reset_keep = 3'h1;
                2'h2:    reset_keep = 3'h2;
                2'h3:    reset_keep = 3'h4;
                default: reset_keep = 3'h0;
            endcase
        end
    endfunction

    wire [2:0]  keep = reset_keep(rst_pick);

    // Output function mux, one copy per pin
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_pin
            reg lvl;
            always @* begin
                case (func_q[4*g +: 4])
                    `GFR_FN_OFF:         lvl = 1'b0;
                    `GFR_FN_TWO_LEVEL:   lvl = i_two_level_wave;
                    `GFR_FN_MULTI_LEVEL: lvl = i_multi_level_wave;
                    `GFR_FN_LEVEL_BIT:   lvl = level_q[g];
                    `GFR_FN_MUTE_BOTH:   lvl = i_automute_left & i_automute_right;
                    `GFR_FN_MUTE_LEFT:   lvl = i_automute_left;
                    `GFR_FN_MUTE_RIGHT:  lvl = i_automute_right;
                    `GFR_FN_CLOCK_BAD:   lvl = clock_bad;
                    `GFR_FN_WARNING:     lvl = i_warning_out_n;
                    `GFR_FN_FAULT:       lvl = i_fault_out_n;
                    `GFR_FN_SPI_CLOCK:   lvl = i_spi_clock;
                    `GFR_FN_SPI_DATA:    lvl = i_spi_pico;
                    // Reserved codes drive low so a stray write cannot toggle a pin
                    default:             lvl = 1'b0;
                endcase
            end
            assign pin_level[g] = lvl ^ invert_q[g];

            always @(posedge i_clock) begin
                if (i_rst) begin
                    pin_q[g]    <= 1'b0;
                    pin_oe_q[g] <= 1'b0;
                end else begin
                    pin_q[g]    <= pin_level[g] & dir_q[g];
                    pin_oe_q[g] <= dir_q[g];
                end
            end
        end
    endgenerate

    // Input routing; inputs are sampled whatever the pin direction
    always @(posedge i_clock) begin
        if (i_rst) begin
            mute_n_q  <= 1'b1;
            hiz_q     <= 1'b0;
            reset_n_q <= 1'b1;
            sync_q    <= 1'b0;
            data_in_q <= 1'b0;
        end else begin
            mute_n_q  <= pick_pin(route_q[`GFR_RT_MUTE_LSB +: 2], i_general_pin, 1'b1);
            hiz_q     <= ~pick_pin(route_q[`GFR_RT_MUTE_LSB +: 2], i_general_pin, 1'b1);
            reset_n_q <= pick_pin(rst_pick, i_general_pin, 1'b1);
            sync_q    <= pick_pin(route_q[`GFR_RT_SYNC_LSB +: 2], i_general_pin, 1'b0);
            data_in_q <= pick_pin(route_q[`GFR_RT_DATA_LSB +: 2], i_general_pin, 1'b0);
        end
    end

    // Interrupt events: fault or warning asserted, clock goes bad, mute input asserted
    assign events[`GFR_EV_FAULT]     = fault_prev_q & ~i_fault_out_n;
    assign events[`GFR_EV_WARNING]   = warn_prev_q & ~i_warning_out_n;
    assign events[`GFR_EV_CLOCK_BAD] = ~clk_bad_prev_q & clock_bad;
    assign events[`GFR_EV_MUTE_IN]   = mute_prev_q & ~mute_n_q;

    always @(posedge i_clock) begin
        if (i_rst) begin
            fault_prev_q   <= 1'b1;
            warn_prev_q    <= 1'b1;
            clk_bad_prev_q <= 1'b0;
            mute_prev_q    <= 1'b1;
            irq_q          <= 1'b0;
        end else begin
            fault_prev_q   <= i_fault_out_n;
            warn_prev_q    <= i_warning_out_n;
            clk_bad_prev_q <= clock_bad;
            mute_prev_q    <= mute_n_q;
            irq_q          <= |(irq_status_q & irq_enable_q);
        end
    end

    // Write channel and register file
    always @* begin
        case (waddr_q)
            `GFR_IDX_PIN_DIR, `GFR_IDX_PIN0_FUNC, `GFR_IDX_PIN1_FUNC, `GFR_IDX_PIN2_FUNC,
            `GFR_IDX_IN_ROUTE, `GFR_IDX_OUT_LEVEL, `GFR_IDX_OUT_INVERT,
            `GFR_IDX_IRQ_CLEAR, `GFR_IDX_IRQ_ENABLE: wr_ok = 1'b1;
            default:                                   wr_ok = 1'b0;
        endcase
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            awready_q    <= 1'b1;
            wready_q     <= 1'b1;
            aw_full_q    <= 1'b0;
            w_full_q     <= 1'b0;
            bvalid_q     <= 1'b0;
            bresp_q      <= `GFR_RESP_OKAY;
            waddr_q      <= `GFR_RST_BYTE;
            wdata_q      <= `GFR_RST_BYTE;
            wlane_q      <= 1'b0;
            dir_q        <= `GFR_RST_PINS;
            func_q       <= `GFR_RST_FUNC;
            route_q      <= `GFR_RST_BYTE;
            level_q      <= `GFR_RST_PINS;
            invert_q     <= `GFR_RST_PINS;
            irq_status_q <= `GFR_RST_IRQ;
            irq_enable_q <= `GFR_RST_IRQ;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                // Upper address bits above the index are ignored
                waddr_q   <= s_axi_awaddr[9:2];
                aw_full_q <= 1'b1;
                awready_q <= 1'b0;
            end
            if (s_axi_wvalid && wready_q) begin
                wdata_q  <= s_axi_wdata[7:0];
                wlane_q  <= s_axi_wstrb[0];
                w_full_q <= 1'b1;
                wready_q <= 1'b0;
            end
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok ? `GFR_RESP_OKAY : `GFR_RESP_SLVERR;
            end
            if (bvalid_q && s_axi_bready) begin
                bvalid_q  <= 1'b0;
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
            if (soft_rst) begin
                // The reset pin keeps its own routing, direction and function
                dir_q    <= dir_q & keep;
                func_q   <= func_q & {{4{keep[2]}}, {4{keep[1]}}, {4{keep[0]}}};
                level_q  <= `GFR_RST_PINS;
                invert_q <= `GFR_RST_PINS;
            end else if (wr_hit) begin
                case (waddr_q)
                    `GFR_IDX_PIN_DIR:    dir_q          <= wdata_q[2:0];
                    `GFR_IDX_PIN0_FUNC:  func_q[3:0]    <= wdata_q[3:0];
                    `GFR_IDX_PIN1_FUNC:  func_q[7:4]    <= wdata_q[3:0];
                    `GFR_IDX_PIN2_FUNC:  func_q[11:8]   <= wdata_q[3:0];
                    `GFR_IDX_IN_ROUTE:   route_q        <= wdata_q;
                    `GFR_IDX_OUT_LEVEL:  level_q        <= wdata_q[2:0];
                    `GFR_IDX_OUT_INVERT: invert_q       <= wdata_q[2:0];
                    `GFR_IDX_IRQ_ENABLE: irq_enable_q   <= wdata_q[3:0];
                    default:             irq_enable_q   <= irq_enable_q;
                endcase
            end
            // A new event in the clearing cycle wins over the clear
            if (wr_hit && waddr_q == `GFR_IDX_IRQ_CLEAR) begin
                irq_status_q <= (irq_status_q & ~wdata_q[3:0]) | events;
            end else begin
                irq_status_q <= irq_status_q | events;
            end
        end
    end

    // Read channel
    always @* begin
        rd_ok = 1'b1;
        case (s_axi_araddr[9:2])
            `GFR_IDX_PIN_DIR:      rd_byte = {5'h00, dir_q};
            `GFR_IDX_PIN0_FUNC:    rd_byte = {4'h0, func_q[3:0]};
            `GFR_IDX_PIN1_FUNC:    rd_byte = {4'h0, func_q[7:4]};
            `GFR_IDX_PIN2_FUNC:    rd_byte = {4'h0, func_q[11:8]};
            `GFR_IDX_IN_ROUTE:     rd_byte = route_q;
            `GFR_IDX_OUT_LEVEL:    rd_byte = {5'h00, level_q};
            `GFR_IDX_OUT_INVERT:   rd_byte = {5'h00, invert_q};
            `GFR_IDX_SILICON_ID:   rd_byte = SILICON_ID;
            `GFR_IDX_STATE_REPORT: rd_byte = {6'h00, i_state_code};
            `GFR_IDX_IRQ_STATUS:   rd_byte = {4'h0, irq_status_q};
            `GFR_IDX_IRQ_CLEAR:    rd_byte = `GFR_RST_BYTE;
            `GFR_IDX_IRQ_ENABLE:   rd_byte = {4'h0, irq_enable_q};
            default: begin
                rd_byte = `GFR_RST_BYTE;
                rd_ok   = 1'b0;
            end
        endcase
    end

    always @(posedge i_clock) begin
        if (i_rst) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `GFR_RESP_OKAY;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= {24'h00_0000, rd_byte};
            rresp_q   <= rd_ok ? `GFR_RESP_OKAY : `GFR_RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign s_axi_awready    = awready_q;
    assign s_axi_wready     = wready_q;
    assign s_axi_bvalid     = bvalid_q;
    assign s_axi_bresp      = bresp_q;
    assign s_axi_arready    = arready_q;
    assign s_axi_rvalid     = rvalid_q;
    assign s_axi_rdata      = rdata_q;
    assign s_axi_rresp      = rresp_q;
    assign o_general_pin    = pin_q;
    assign o_general_pin_oe = pin_oe_q;
    assign o_mute_n         = mute_n_q;
    assign o_hiz_request    = hiz_q;
    assign o_reset_n        = reset_n_q;
    assign o_phase_sync     = sync_q;
    assign o_serial_data_in = data_in_q;
    assign o_irq            = irq_q;

endmodule // gfr_router

/* File: rtl/gfr_defines.vh */
`ifndef GFR_DEFINES_VH
`define GFR_DEFINES_VH

// Register indices; byte address is four times the index
`define GFR_IDX_PIN_DIR       8'h60
`define GFR_IDX_PIN0_FUNC     8'h61
`define GFR_IDX_PIN1_FUNC     8'h62
`define GFR_IDX_PIN2_FUNC     8'h63
`define GFR_IDX_IN_ROUTE      8'h64
`define GFR_IDX_OUT_LEVEL     8'h65
`define GFR_IDX_OUT_INVERT    8'h66
`define GFR_IDX_SILICON_ID    8'h67
`define GFR_IDX_STATE_REPORT  8'h68
`define GFR_IDX_IRQ_STATUS    8'h70
`define GFR_IDX_IRQ_CLEAR     8'h71
`define GFR_IDX_IRQ_ENABLE    8'h72

// Reset values
`define GFR_RST_BYTE          8'h00
`define GFR_RST_FUNC          12'h000
`define GFR_RST_PINS          3'h0
`define GFR_RST_IRQ           4'h0

// Field positions of the input routing register
`define GFR_RT_MUTE_LSB       0
`define GFR_RT_RESET_LSB      2
`define GFR_RT_SYNC_LSB       4
`define GFR_RT_DATA_LSB       6

// Output function codes
`define GFR_FN_OFF            4'h0
`define GFR_FN_TWO_LEVEL      4'h1
`define GFR_FN_LEVEL_BIT      4'h2
`define GFR_FN_MUTE_BOTH      4'h3
`define GFR_FN_MUTE_LEFT      4'h4
`define GFR_FN_MUTE_RIGHT     4'h5
`define GFR_FN_CLOCK_BAD      4'h6
`define GFR_FN_WARNING        4'h8
`define GFR_FN_MULTI_LEVEL    4'h9
`define GFR_FN_FAULT          4'hB
`define GFR_FN_SPI_CLOCK      4'hC
`define GFR_FN_SPI_DATA       4'hD

// Input routing codes
`define GFR_RT_NONE           2'h0

// Interrupt event bit positions
`define GFR_EV_FAULT          0
`define GFR_EV_WARNING        1
`define GFR_EV_CLOCK_BAD      2
`define GFR_EV_MUTE_IN        3

// Bus responses
`define GFR_RESP_OKAY         2'h0
`define GFR_RESP_SLVERR       2'h2

`endif

/* File: verif/gfr_router_sva.sv */
`timescale 1ns/1ps
module gfr_router_sva (
    // Clock and reset
    input logic        i_clock,
    input logic        i_rst,
    // Register bus
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    // Pins and status
    input logic [2:0]  o_general_pin,
    input logic [2:0]  o_general_pin_oe,
    input logic        o_mute_n,
    input logic        o_hiz_request,
    input logic        o_irq
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);

    wr_resp_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response not two cycles after take");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before handshake");
    rd_resp_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not one cycle after take");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before handshake");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    input_pin_low_a: assert property ((o_general_pin & ~o_general_pin_oe) == 3'h0)
        else $error("pin level driven while not enabled");
    hiz_follow_a: assert property (o_hiz_request == !o_mute_n)
        else $error("high impedance request does not follow mute input");
    reset_clean_a: assert property ($past(i_rst) |-> o_general_pin_oe == 3'h0 && !o_irq && o_mute_n)
        else $error("outputs not idle after reset");
endmodule // gfr_router_sva

/* File: verif/gfr_pin_model.sv */
`timescale 1ns/1ps
module gfr_pin_model (
    // Device side
    input  logic [2:0] i_oe,
    input  logic [2:0] i_drv,
    // External source
    input  logic [2:0] i_ext,
    output logic [2:0] o_wire
);
    // The outside circuit always drives an undriven pin, so no level floats
    assign o_wire = (i_oe & i_drv) | (~i_oe & i_ext);
endmodule // gfr_pin_model

/* File: verif/gfr_router_bench.sv */
`timescale 1ns/1ps
`include "gfr_defines.vh"
module gfr_router_bench;
    logic        i_clock = 0;
    logic        i_rst = 1;
    logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [31:0] aa = 0, wd = 0, ara = 0;
    logic [9:0]  src = 0;
    logic [2:0]  ext = 0;
    logic [1:0]  st = 0;
    wire         awr, wrdy, bv, arr, rv, mute_n, hiz, rst_n, sync, sdi, irq;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdat;
    wire  [2:0]  pin, pout, oe;
    int          fails = 0, check_count = 0;
    logic [9:0]  pats [4] = '{10'h3FF, 10'h155, 10'h2AA, 10'h000};
    // Every defined code plus reserved code A; reserved codes 7, E and F are never written
    logic [3:0]  codes [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};

    always #5 i_clock = ~i_clock;

    gfr_router #(.SILICON_ID(8'hC3)) dut (  // Arbitrary identifier value
        .i_clock(i_clock), .i_rst(i_rst),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(aa), .s_axi_awprot(3'h0),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
        .i_two_level_wave(src[0]), .i_multi_level_wave(src[1]), .i_automute_left(src[2]),
        .i_automute_right(src[3]), .i_clock_error(src[4]), .i_clock_missing(src[5]),
        .i_warning_out_n(src[6]), .i_fault_out_n(src[7]), .i_spi_clock(src[8]), .i_spi_pico(src[9]),
        .i_state_code(st), .i_general_pin(pin), .o_general_pin(pout), .o_general_pin_oe(oe),
        .o_mute_n(mute_n), .o_hiz_request(hiz), .o_reset_n(rst_n), .o_phase_sync(sync),
        .o_serial_data_in(sdi), .o_irq(irq));

    gfr_pin_model pm (.i_oe(oe), .i_drv(pout), .i_ext(ext), .o_wire(pin));

    task print_verdict;
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task idle(input int k);
        repeat (k) @(posedge i_clock);
    endtask

    task wr(input [7:0] ix, input [7:0] d, input [1:0] er);
        int n;
        n = 0;
        @(posedge i_clock);
        aa <= {22'h0, ix, 2'b00};
        wd <= {24'h00_0000, d};
        awv <= 1;
        wv <= 1;
        br <= 1;
        do begin
            @(posedge i_clock);
            n++;
            if (awv && awr) awv <= 0;
            if (wv && wrdy) wv <= 0;
        end while (!bv && n < 50);
        br <= 0;
        // A write that never answers counts against the run
        chk("write answer", 1, bv);
        chk("write response", er, bresp);
    endtask

    task rd(input [7:0] ix, input [31:0] e, input [1:0] er, input string nm);
        int n;
        n = 0;
        @(posedge i_clock);
        ara <= {22'h0, ix, 2'b00};
        arv <= 1;
        rr <= 1;
        do begin
            @(posedge i_clock);
            n++;
            if (arv && arr) arv <= 0;
        end while (!rv && n < 50);
        rr <= 0;
        chk("read answer", 1, rv);
        chk(nm, e, rdat);
        chk("read response", er, rresp);
    endtask

    function logic ef(input [3:0] c, input [9:0] s, input l);
        case (c)
            4'h1: ef = s[0];
            4'h9: ef = s[1];
            4'h2: ef = l;
            4'h3: ef = s[2] & s[3];
            4'h4: ef = s[2];
            4'h5: ef = s[3];
            4'h6: ef = s[4] | s[5];
            4'h8: ef = s[6];
            4'hB: ef = s[7];
            4'hC: ef = s[8];
            4'hD: ef = s[9];
            default: ef = 1'b0;
        endcase
    endfunction

    task t_regs;
        for (int i = 8'h60; i <= 8'h66; i++) rd(i, 0, `GFR_RESP_OKAY, "reset value");
        rd(8'h67, 32'h0000_00C3, `GFR_RESP_OKAY, "identifier");
        for (int c = 0; c < 4; c++) begin
            st <= c[1:0];
            rd(8'h68, c, `GFR_RESP_OKAY, "state report");
        end
        rd(8'h7F, 0, `GFR_RESP_SLVERR, "unmapped read");
        wr(8'h67, 8'h11, `GFR_RESP_SLVERR);
        rd(8'h67, 32'h0000_00C3, `GFR_RESP_OKAY, "identifier kept");
    endtask

    task t_func;
        int p;
        wr(8'h60, 8'h07, `GFR_RESP_OKAY);
        for (int i = 0; i < 13; i++) begin
            p = i % 3;
            wr(8'h61 + p, {4'h0, codes[i]}, `GFR_RESP_OKAY);
            for (int k = 0; k < 4; k++) begin
                src <= pats[k];
                wr(8'h65, {5'h00, pats[k][2:0]}, `GFR_RESP_OKAY);
                idle(3);
                chk("pin level", ef(codes[i], pats[k], pats[k][p]), pout[p]);
            end
        end
        chk("drive enable", 3'h7, oe);
        // Sources now all low: pins carry data, fault and clock functions, all low before inversion
        wr(8'h66, 8'h07, `GFR_RESP_OKAY);
        idle(3);
        chk("inverted pins", 3'h7, pout);
        wr(8'h60, 8'h00, `GFR_RESP_OKAY);
        idle(3);
        chk("released pins", 6'h00, {oe, pout});
        wr(8'h66, 8'h00, `GFR_RESP_OKAY);
    endtask

    task t_route;
        wr(8'h64, 8'h63, `GFR_RESP_OKAY);
        for (int e = 0; e < 8; e++) begin
            ext <= e[2:0];
            idle(3);
            chk("routed inputs", {e[2], !e[2], e[1], e[0]}, {mute_n, hiz, sync, sdi});
        end
        wr(8'h64, 8'h00, `GFR_RESP_OKAY);
        ext <= 3'h0;
        idle(3);
        chk("unrouted inputs", 4'h9, {mute_n, sync, sdi, rst_n});
    endtask

    task t_pinrst;
        wr(8'h60, 8'h01, `GFR_RESP_OKAY);
        wr(8'h61, 8'h02, `GFR_RESP_OKAY);
        wr(8'h63, 8'h02, `GFR_RESP_OKAY);
        wr(8'h65, 8'h01, `GFR_RESP_OKAY);
        ext <= 3'h4;
        wr(8'h64, 8'h0C, `GFR_RESP_OKAY);
        idle(2);
        chk("pin before reset", 2'h3, {oe[0], pout[0]});
        ext <= 3'h0;
        // Reset flop samples the pin, then direction clear, then drive enable: three edges
        idle(4);
        chk("pin reset active", 2'h0, {rst_n, oe[0]});
        ext <= 3'h4;
        idle(3);
        chk("pin reset released", 1, rst_n);
        rd(8'h63, 2, `GFR_RESP_OKAY, "reset pin code kept");
        rd(8'h61, 0, `GFR_RESP_OKAY, "other code cleared");
        wr(8'h64, 8'h00, `GFR_RESP_OKAY);
    endtask

    task t_irq;
        src <= 10'h3FF;
        idle(2);
        wr(8'h72, 8'h01, `GFR_RESP_OKAY);
        // Earlier scenarios raised every event: fault, warning, clock bad and mute input
        rd(8'h70, 32'h0000_000F, `GFR_RESP_OKAY, "all events");
        wr(8'h71, 8'h0F, `GFR_RESP_OKAY);
        idle(2);
        chk("irq idle", 0, irq);
        rd(8'h71, 0, `GFR_RESP_OKAY, "clear register");
        src <= 10'h37F;
        idle(3);
        chk("irq raised", 1, irq);
        rd(8'h70, 1, `GFR_RESP_OKAY, "status");
        wr(8'h71, 8'h01, `GFR_RESP_OKAY);
        idle(2);
        chk("irq cleared", 0, irq);
        wr(8'h72, 8'h00, `GFR_RESP_OKAY);
        src <= 10'h3FF;
        idle(2);
        src <= 10'h37F;
        idle(3);
        chk("irq masked", 0, irq);
        rd(8'h70, 1, `GFR_RESP_OKAY, "masked status");
        wr(8'h72, 8'h01, `GFR_RESP_OKAY);
        idle(2);
        chk("irq unmasked", 1, irq);
        wr(8'h71, 8'h0F, `GFR_RESP_OKAY);
        idle(2);
        chk("irq final", 0, irq);
    endtask

    initial begin
        #200_000;
        fails++;
        print_verdict();
    end

    initial begin
        repeat (8) @(posedge i_clock);
        i_rst <= 0;
        t_regs();
        t_func();
        t_route();
        t_pinrst();
        t_irq();
        print_verdict();
    end
endmodule // gfr_router_bench

bind gfr_router gfr_router_sva chk_i (.*);
